// File: core/vcp_pipe.sv
/*
  phase sequencer of an eight-wide long-instruction-word pipeline: four
  fetch phases, dispatch, decode and up to five execute phases.
  assumes: program and data memory run on CLK with a fixed latency of two
  cycles from request to data; one pipeline phase is one CLK period.
*/
`timescale 1ns/1ps
module vcp_pipe #(
  parameter logic [31:0] START_PC = vcp_pkg::RESET_PC
) (
  input wire logic CLK,
  input wire logic RESET_N,
  output logic PMEM_REQ,
  output logic [31:0] PMEM_ADDR,
  input wire logic [vcp_pkg::FPW-1:0] PMEM_RDATA,
  output logic DMEM_RD,
  output logic DMEM_WR,
  output logic [31:0] DMEM_ADDR,
  output logic [31:0] DMEM_WDATA,
  input wire logic [31:0] DMEM_RDATA,
  input wire logic SAT_CLEAR,
  output logic SAT_FLAG,
  output logic [vcp_pkg::NPH-1:0] PHASE_BUSY
);
  localparam int L = vcp_pkg::LANES;
  localparam int NWP = 2 * L + 1; // E1 and E2 port per lane, one load port

  // fetch side state
  logic run_r; // address generate active
  logic [31:0] pg_a_r; // address held in address generate
  logic [31:0] fetch_a; // address leaving address generate this cycle
  logic [31:0] replay_a; // oldest fetch still in flight
  logic pw_v_r, pr_v_r; // wait and receive occupancy
  logic [31:0] pw_a_r, pr_a_r; // their addresses, kept for replay
  // dispatch state
  logic [vcp_pkg::FPW-1:0] dp_fp_r; // fetch packet being split
  logic [7:0] dp_rem_r; // slots not yet dispatched
  logic [7:0] par; // parallel bits of the held packet
  logic [7:0] ep_sel; // slots of the execute packet leaving now
  logic hold; // more execute packets remain after this one
  logic [vcp_pkg::IW-1:0] route_i [L]; // instruction per unit
  logic route_v [L];
  logic dc_v [L]; // decode occupancy per lane, copied out of the interface array
  // execute state per lane
  logic e1_v [L];
  vcp_pkg::vcp_cls_e e1_cls [L];
  logic [3:0] e1_dst [L], e1_s1 [L];
  logic [7:0] e1_imm [L];
  logic e1_pen [L];
  logic go [L]; // predicate true in first execute
  logic [31:0] sres [L], mres [L]; // single and multiply results
  logic ssat [L], msat [L];
  logic e2_mv [L]; // multiply result pending
  logic [3:0] e2_dst [L];
  logic [31:0] e2_mres [L];
  logic e2_ssat_r, e2_msat_r, e3_msat_r; // saturation events in flight
  logic e3_ld_r, e4_ld_r, e5_v_r; // load occupancy E3..E5
  logic [3:0] e2_ldst_r, e3_dst_r, e4_dst_r, e5_dst_r;
  logic [31:0] e5_data_r; // load data captured at the boundary
  logic br_go, mem_go, mem_ld, ssat_any, msat_any;
  logic [31:0] br_tgt, mem_addr, mem_wd;
  logic [3:0] mem_dst;
  logic [vcp_pkg::NPH-1:0] ph_nxt;
  // register file ports
  logic [3:0] ra [3*L];
  logic [31:0] rd [3*L];
  logic we [NWP];
  logic [3:0] wa [NWP];
  logic [31:0] wd [NWP];

  vcp_dec_if dif [L] ();

  // pick the run of parallel slots starting at the first undispatched one
  function automatic logic [7:0] ep_pick(input logic [7:0] rem, input logic [7:0] p);
    logic open;
    logic [7:0] ep;
    open = 1'b1;
    ep = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (rem[i] && open) begin
        ep[i] = 1'b1;
        open = p[i]; // a clear parallel bit closes the packet
      end
    end
    return ep;
  endfunction : ep_pick

  // address generate: branch target first, else replay, else sequential
  always_comb begin
    replay_a = pr_v_r ? pr_a_r : (pw_v_r ? pw_a_r : (PMEM_REQ ? PMEM_ADDR : pg_a_r));
    if (br_go) begin
      fetch_a = br_tgt;
    end else if (hold) begin
      fetch_a = replay_a;
    end else begin
      fetch_a = pg_a_r;
    end
  end

  // fetch phases; a hold kills in-flight fetches and replays them later,
  // trading a few bubbles for needing no packet buffer
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      run_r <= 1'b0;
      pg_a_r <= START_PC;
      PMEM_REQ <= 1'b0;
      PMEM_ADDR <= START_PC;
      pw_v_r <= 1'b0;
      pr_v_r <= 1'b0;
      pw_a_r <= START_PC;
      pr_a_r <= START_PC;
    end else begin
      run_r <= 1'b1;
      // hold the start address until it has been sent once
      pg_a_r <= (hold || !run_r) ? fetch_a : fetch_a + vcp_pkg::FP_BYTES;
      PMEM_REQ <= run_r && !hold;
      PMEM_ADDR <= fetch_a;
      pw_v_r <= PMEM_REQ && !hold;
      pw_a_r <= PMEM_ADDR;
      pr_v_r <= pw_v_r && !hold;
      pr_a_r <= pw_a_r;
    end
  end

  // parallel bits and current execute packet
  always_comb begin
    for (int s = 0; s < vcp_pkg::SLOTS; s++) begin
      par[s] = dp_fp_r[s*vcp_pkg::IW + vcp_pkg::F_PAR];
    end
    ep_sel = ep_pick(dp_rem_r, par);
    hold = |(dp_rem_r & ~ep_sel);
  end

  // receive phase capture and dispatch bookkeeping
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      dp_rem_r <= 8'h00;
      dp_fp_r <= '0;
    end else if (hold) begin
      dp_rem_r <= dp_rem_r & ~ep_sel;
    end else if (pr_v_r) begin
      dp_rem_r <= 8'hff;
      dp_fp_r <= PMEM_RDATA;
    end else begin
      dp_rem_r <= 8'h00;
    end
  end

  // route each non-no-op slot of the packet to its unit, lowest slot wins
  always_comb begin
    for (int u = 0; u < L; u++) begin
      route_v[u] = 1'b0;
      route_i[u] = '0;
      for (int s = vcp_pkg::SLOTS - 1; s >= 0; s--) begin
        if (ep_sel[s] && vcp_pkg::ins_unit(dp_fp_r[s*vcp_pkg::IW +: vcp_pkg::IW]) == 3'(u)
            && vcp_pkg::ins_cls(dp_fp_r[s*vcp_pkg::IW +: vcp_pkg::IW]) != vcp_pkg::CLS_NOP) begin
          route_v[u] = 1'b1;
          route_i[u] = dp_fp_r[s*vcp_pkg::IW +: vcp_pkg::IW];
        end
      end
    end
  end

  // one decoder per unit, and the register file address hookup
  for (genvar g = 0; g < L; g++) begin : g_lane
    assign dif[g].instr = route_i[g];
    assign dif[g].instr_v = route_v[g];
    assign dc_v[g] = dif[g].v;
    assign ra[3*g] = dif[g].s1;
    assign ra[3*g+1] = dif[g].s2;
    assign ra[3*g+2] = dif[g].prg;
    vcp_unit_dec u_dec (
      .clk(CLK),
      .rst_n(RESET_N),
      .dif(dif[g])
    );
    // decode to first execute hand-over
    always_ff @(posedge CLK) begin
      if (!RESET_N) begin
        e1_v[g] <= 1'b0;
        e1_cls[g] <= vcp_pkg::CLS_NOP;
        e1_dst[g] <= 4'h0;
        e1_s1[g] <= 4'h0;
        e1_imm[g] <= 8'h00;
        e1_pen[g] <= 1'b0;
      end else begin
        e1_v[g] <= dif[g].v;
        e1_cls[g] <= dif[g].cls;
        e1_dst[g] <= dif[g].dst;
        e1_s1[g] <= dif[g].s1;
        e1_imm[g] <= dif[g].imm;
        e1_pen[g] <= dif[g].pen;
      end
    end
  end

  // first execute: predicate, operands, single-cycle and multiply arithmetic
  always_comb begin
    logic [32:0] sum;
    logic signed [31:0] prod;
    sum = '0;
    prod = '0;
    for (int l = 0; l < L; l++) begin
      go[l] = e1_v[l] && (!e1_pen[l] || (rd[3*l+2] != 32'h0));
      sum = {rd[3*l][31], rd[3*l]} + {rd[3*l+1][31], rd[3*l+1]};
      ssat[l] = go[l] && e1_cls[l] == vcp_pkg::CLS_SINGLE && sum[32] != sum[31];
      sres[l] = (sum[32] != sum[31]) ? (sum[32] ? vcp_pkg::SAT_NEG : vcp_pkg::SAT_POS)
                                     : sum[31:0];
      prod = $signed(rd[3*l][15:0]) * $signed(rd[3*l+1][15:0]);
      msat[l] = go[l] && e1_cls[l] == vcp_pkg::CLS_MUL && rd[3*l][15:0] == vcp_pkg::HALF_MIN
                && rd[3*l+1][15:0] == vcp_pkg::HALF_MIN;
      mres[l] = msat[l] ? vcp_pkg::SAT_POS : {prod[30:0], 1'b0};
      // E1 write port: single result or pointer update
      we[2*l] = go[l] && (e1_cls[l] == vcp_pkg::CLS_SINGLE || e1_cls[l] == vcp_pkg::CLS_LOAD
                || e1_cls[l] == vcp_pkg::CLS_STORE);
      wa[2*l] = (e1_cls[l] == vcp_pkg::CLS_SINGLE) ? e1_dst[l] : e1_s1[l];
      wd[2*l] = (e1_cls[l] == vcp_pkg::CLS_SINGLE) ? sres[l]
                : rd[3*l] + {{24{e1_imm[l][7]}}, e1_imm[l]};
      // E2 write port: multiply result, one delay slot later
      we[2*l+1] = e2_mv[l];
      wa[2*l+1] = e2_dst[l];
      wd[2*l+1] = e2_mres[l];
    end
    we[NWP-1] = e5_v_r;
    wa[NWP-1] = e5_dst_r;
    wd[NWP-1] = e5_data_r;
  end

  // branch and data memory selection, lowest lane first
  always_comb begin
    br_go = 1'b0;
    br_tgt = 32'h0;
    mem_go = 1'b0;
    mem_ld = 1'b0;
    mem_addr = 32'h0;
    mem_wd = 32'h0;
    mem_dst = 4'h0;
    ssat_any = 1'b0;
    msat_any = 1'b0;
    for (int l = L - 1; l >= 0; l--) begin
      ssat_any = ssat_any || ssat[l];
      msat_any = msat_any || msat[l];
      if (go[l] && e1_cls[l] == vcp_pkg::CLS_BRANCH) begin
        br_go = 1'b1;
        br_tgt = rd[3*l] & vcp_pkg::FP_ALIGN;
      end
      if (go[l] && (e1_cls[l] == vcp_pkg::CLS_LOAD || e1_cls[l] == vcp_pkg::CLS_STORE)) begin
        mem_go = 1'b1;
        mem_ld = e1_cls[l] == vcp_pkg::CLS_LOAD;
        mem_addr = rd[3*l];
        mem_wd = rd[3*l+1];
        mem_dst = e1_dst[l];
      end
    end
  end

  // second execute: multiply pending per lane
  always_ff @(posedge CLK) begin
    for (int l = 0; l < L; l++) begin
      if (!RESET_N) begin
        e2_mv[l] <= 1'b0;
        e2_dst[l] <= 4'h0;
        e2_mres[l] <= 32'h0;
      end else begin
        e2_mv[l] <= go[l] && e1_cls[l] == vcp_pkg::CLS_MUL;
        e2_dst[l] <= e1_dst[l];
        e2_mres[l] <= mres[l];
      end
    end
  end

  // data memory request, visible during the second execute phase
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      DMEM_RD <= 1'b0;
      DMEM_WR <= 1'b0;
      DMEM_ADDR <= 32'h0;
      DMEM_WDATA <= 32'h0;
      e2_ldst_r <= 4'h0;
    end else begin
      DMEM_RD <= mem_go && mem_ld;
      DMEM_WR <= mem_go && !mem_ld;
      DMEM_ADDR <= mem_addr;
      DMEM_WDATA <= mem_wd;
      e2_ldst_r <= mem_dst;
    end
  end

  // load track through third to fifth execute; data sampled end of fourth
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      e3_ld_r <= 1'b0;
      e4_ld_r <= 1'b0;
      e5_v_r <= 1'b0;
      e3_dst_r <= 4'h0;
      e4_dst_r <= 4'h0;
      e5_dst_r <= 4'h0;
      e5_data_r <= 32'h0;
    end else begin
      e3_ld_r <= DMEM_RD;
      e4_ld_r <= e3_ld_r;
      e5_v_r <= e4_ld_r;
      e3_dst_r <= e2_ldst_r;
      e4_dst_r <= e3_dst_r;
      e5_dst_r <= e4_dst_r;
      e5_data_r <= DMEM_RDATA;
    end
  end

  // sticky saturation bit of the control status register; a set wins
  // over a clear arriving in the same cycle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      e2_ssat_r <= 1'b0;
      e2_msat_r <= 1'b0;
      e3_msat_r <= 1'b0;
      SAT_FLAG <= 1'b0;
    end else begin
      e2_ssat_r <= ssat_any;
      e2_msat_r <= msat_any;
      e3_msat_r <= e2_msat_r;
      SAT_FLAG <= (SAT_FLAG && !SAT_CLEAR) || e2_ssat_r || e3_msat_r;
    end
  end

  // phase occupancy for the next cycle
  always_comb begin
    ph_nxt = '0;
    ph_nxt[vcp_pkg::PH_PG] = 1'b1;
    ph_nxt[vcp_pkg::PH_PS] = run_r && !hold;
    ph_nxt[vcp_pkg::PH_PW] = PMEM_REQ && !hold;
    ph_nxt[vcp_pkg::PH_PR] = pw_v_r && !hold;
    ph_nxt[vcp_pkg::PH_DP] = hold || pr_v_r;
    for (int l = 0; l < L; l++) begin
      ph_nxt[vcp_pkg::PH_DC] = ph_nxt[vcp_pkg::PH_DC] || route_v[l];
      ph_nxt[vcp_pkg::PH_E1] = ph_nxt[vcp_pkg::PH_E1] || dc_v[l];
      ph_nxt[vcp_pkg::PH_E2] = ph_nxt[vcp_pkg::PH_E2] || (go[l] && e1_cls[l] == vcp_pkg::CLS_MUL);
      ph_nxt[vcp_pkg::PH_E3] = ph_nxt[vcp_pkg::PH_E3] || e2_mv[l];
    end
    // a saturating single-cycle op still sets the flag in the second phase
    ph_nxt[vcp_pkg::PH_E2] = ph_nxt[vcp_pkg::PH_E2] || mem_go || ssat_any;
    ph_nxt[vcp_pkg::PH_E3] = ph_nxt[vcp_pkg::PH_E3] || DMEM_RD || DMEM_WR;
    ph_nxt[vcp_pkg::PH_E4] = e3_ld_r;
    ph_nxt[vcp_pkg::PH_E5] = e4_ld_r;
  end

  // occupancy register: every packet moves one phase per cycle, except a fetch packet held in dispatch and the in-flight fetches a hold kills
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      PHASE_BUSY <= '0;
    end else begin
      PHASE_BUSY <= ph_nxt;
    end
  end

  vcp_regfile #(
    .NR(3 * L),
    .NW(NWP),
    .DEPTH(vcp_pkg::NREG),
    .W(vcp_pkg::DW),
    .AW(vcp_pkg::RAW)
  ) u_rf (
    .clk(CLK),
    .ra(ra),
    .rd(rd),
    .we(we),
    .wa(wa),
    .wd(wd)
  );
endmodule : vcp_pipe

// File: core/vcp_pkg.sv
/*
  shared constants, instruction field layout and class codes for the
  eight-wide pipeline phase sequencer.
  assumes: one clock domain; instructions are 32-bit words, eight to a
  fetch packet, in the local encoding laid out below.
*/
package vcp_pkg;
  localparam int LANES = 8; // functional units, selected by the unit field of each slot
  localparam int SLOTS = 8; // instruction slots in a fetch packet
  localparam int IW = 32; // instruction width
  localparam int DW = 32; // data and address width
  localparam int RAW = 4; // register address width
  localparam int NREG = 16; // register file depth
  localparam int FPW = SLOTS * IW; // fetch packet width
  localparam logic [31:0] FP_BYTES = 32'h20; // address step per fetch packet
  localparam logic [31:0] RESET_PC = 32'h0; // first fetch address
  localparam logic [31:0] FP_ALIGN = 32'hffffffe0; // branch target alignment mask
  localparam logic [31:0] SAT_POS = 32'h7fffffff; // positive saturation value
  localparam logic [31:0] SAT_NEG = 32'h80000000; // negative saturation value
  localparam logic [15:0] HALF_MIN = 16'h8000; // most negative 16-bit operand
  // instruction field positions
  localparam int F_PAR = 0; // 1: next slot runs in parallel with this one
  localparam int F_CLS = 1; // class, 3 bits
  localparam int F_UNIT = 4; // target functional unit, 3 bits
  localparam int F_DST = 7; // destination register
  localparam int F_S1 = 11; // first source / pointer / branch target register
  localparam int F_S2 = 15; // second source / store data register
  localparam int F_PEN = 19; // predicate enable
  localparam int F_PRG = 20; // predicate register
  localparam int F_IMM = 24; // signed 8-bit pointer step
  // phase occupancy bit positions
  localparam int PH_PG = 0;
  localparam int PH_PS = 1;
  localparam int PH_PW = 2;
  localparam int PH_PR = 3;
  localparam int PH_DP = 4;
  localparam int PH_DC = 5;
  localparam int PH_E1 = 6;
  localparam int PH_E2 = 7;
  localparam int PH_E3 = 8;
  localparam int PH_E4 = 9;
  localparam int PH_E5 = 10;
  localparam int NPH = 11;

  // instruction classes
  typedef enum logic [2:0] {
    CLS_NOP = 3'h0,
    CLS_SINGLE = 3'h1,
    CLS_MUL = 3'h2,
    CLS_LOAD = 3'h3,
    CLS_STORE = 3'h4,
    CLS_BRANCH = 3'h5
  } vcp_cls_e;

  // class field of an instruction
  function automatic vcp_cls_e ins_cls(input logic [IW-1:0] i);
    return vcp_cls_e'(i[F_CLS +: 3]);
  endfunction : ins_cls

  // unit field of an instruction
  function automatic logic [2:0] ins_unit(input logic [IW-1:0] i);
    return i[F_UNIT +: 3];
  endfunction : ins_unit

  // a register address field starting at pos
  function automatic logic [RAW-1:0] ins_reg(input logic [IW-1:0] i, input int pos);
    return i[pos +: RAW];
  endfunction : ins_reg
endpackage : vcp_pkg

// File: core/vcp_dec_if.sv
/*
  carrier between the dispatcher and one functional unit decoder.
  assumes: driven and sampled on the single pipeline clock.
*/
`timescale 1ns/1ps
interface vcp_dec_if;
  logic [vcp_pkg::IW-1:0] instr; // routed instruction, dispatch phase
  logic instr_v; // a real instruction is routed to this unit
  logic v; // decode phase slot holds an instruction
  vcp_pkg::vcp_cls_e cls; // decoded class
  logic [vcp_pkg::RAW-1:0] dst; // destination register
  logic [vcp_pkg::RAW-1:0] s1; // first source register
  logic [vcp_pkg::RAW-1:0] s2; // second source register
  logic [vcp_pkg::RAW-1:0] prg; // predicate register
  logic pen; // predicate enabled
  logic [7:0] imm; // pointer step

  modport disp (output instr, output instr_v, input v, input cls, input dst, input s1,
                input s2, input prg, input pen, input imm);
  modport unit (input instr, input instr_v, output v, output cls, output dst, output s1,
                output s2, output prg, output pen, output imm);
endinterface : vcp_dec_if

// File: core/vcp_unit_dec.sv
/*
  decode phase register of one functional unit.
  assumes: the dispatcher presents at most one instruction per cycle;
  fields are valid one cycle after instr_v.
*/
`timescale 1ns/1ps
module vcp_unit_dec (
  input wire logic clk,
  input wire logic rst_n,
  vcp_dec_if.unit dif
);
  // decode slot occupancy; an empty slot stays empty for unrouted no-ops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dif.v <= 1'b0;
    end else begin
      dif.v <= dif.instr_v;
    end
  end

  // split the routed word into its register and path fields
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dif.cls <= vcp_pkg::CLS_NOP;
      dif.dst <= '0;
      dif.s1 <= '0;
      dif.s2 <= '0;
      dif.prg <= '0;
      dif.pen <= 1'b0;
      dif.imm <= 8'h00;
    end else begin
      dif.cls <= vcp_pkg::ins_cls(dif.instr);
      dif.dst <= vcp_pkg::ins_reg(dif.instr, vcp_pkg::F_DST);
      dif.s1 <= vcp_pkg::ins_reg(dif.instr, vcp_pkg::F_S1);
      dif.s2 <= vcp_pkg::ins_reg(dif.instr, vcp_pkg::F_S2);
      dif.prg <= vcp_pkg::ins_reg(dif.instr, vcp_pkg::F_PRG);
      dif.pen <= dif.instr[vcp_pkg::F_PEN];
      dif.imm <= dif.instr[vcp_pkg::F_IMM +: 8];
    end
  end
endmodule : vcp_unit_dec

// File: core/vcp_regfile.sv
/*
  multi-port register file with registered read data and write-through.
  assumes: one clock; if two write ports hit one address in a cycle the
  higher-numbered port wins (no interlocks guard against that).
*/
`timescale 1ns/1ps
module vcp_regfile #(
  parameter int NR = 24,
  parameter int NW = 17,
  parameter int DEPTH = 16,
  parameter int W = 32,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic [AW-1:0] ra [NR],
  output logic [W-1:0] rd [NR],
  input wire logic we [NW],
  input wire logic [AW-1:0] wa [NW],
  input wire logic [W-1:0] wd [NW]
);
  logic [W-1:0] mem [DEPTH]; // storage, no reset: contents are software state
  logic [W-1:0] byp [NR]; // read value with same-cycle writes forwarded

  // forward a write landing this cycle so the next packet sees it
  always_comb begin
    for (int r = 0; r < NR; r++) begin
      byp[r] = mem[ra[r]];
      for (int w = 0; w < NW; w++) begin
        if (we[w] && (wa[w] == ra[r])) begin
          byp[r] = wd[w];
        end
      end
    end
  end

  // write ports, later ports take priority
  always_ff @(posedge clk) begin
    for (int w = 0; w < NW; w++) begin
      if (we[w]) begin
        mem[wa[w]] <= wd[w];
      end
    end
  end

  // registered read data
  always_ff @(posedge clk) begin
    for (int r = 0; r < NR; r++) begin
      rd[r] <= byp[r];
    end
  end
endmodule : vcp_regfile

// File: testbench/vcp_mem_model.sv
/*
  program and data memory model for the phase sequencer.
  assumes: both answer two cycles after the request cycle, no handshake.
*/
`timescale 1ns/1ps
module vcp_mem_model (
  input wire logic clk,
  input wire logic pmem_req,
  input wire logic [31:0] pmem_addr,
  output logic [vcp_pkg::FPW-1:0] pmem_rdata = '0,
  input wire logic dmem_rd,
  input wire logic dmem_wr,
  input wire logic [31:0] dmem_addr,
  input wire logic [31:0] dmem_wdata,
  output logic [31:0] dmem_rdata = '0
);
  logic [vcp_pkg::FPW-1:0] prog [64]; // fetch packets, loaded by the bench
  logic [31:0] dm [16]; // data words
  logic pv_r = 1'b0; // program read in flight
  logic dv_r = 1'b0; // data read in flight
  logic [31:0] pa_r; // program address in flight
  logic [31:0] da_r; // data address in flight
  // program read: access in the wait cycle, hold time over means garbage
  always @(posedge clk) begin
    pv_r <= pmem_req;
    pa_r <= pmem_addr;
    pmem_rdata <= pv_r ? prog[int'(pa_r[10:5])] : ~pmem_rdata;
  end
  // data side: an undriven address decodes to some word, like real decoders
  always @(posedge clk) begin
    dv_r <= dmem_rd;
    da_r <= dmem_addr;
    dmem_rdata <= dv_r ? dm[int'(da_r[5:2])] : ~dmem_rdata;
    if (dmem_wr) begin
      dm[int'(dmem_addr[5:2])] <= dmem_wdata;
    end
  end
endmodule : vcp_mem_model

// File: testbench/vcp_pipe_assertions.sv
/*
  port checker for the phase sequencer.
  assumes: bound to vcp_pipe; PHASE_BUSY bit 5 decode, 6..10 execute.
*/
`timescale 1ns/1ps
module vcp_pipe_assertions #(
  parameter logic [31:0] START_PC = 32'h0
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PMEM_REQ,
  input wire logic [31:0] PMEM_ADDR,
  input wire logic DMEM_RD,
  input wire logic DMEM_WR,
  input wire logic SAT_CLEAR,
  input wire logic SAT_FLAG,
  input wire logic [vcp_pkg::NPH-1:0] PHASE_BUSY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_reset_empty: assert property (disable iff (1'b0)
    !RESET_N |=> PHASE_BUSY == '0 && !PMEM_REQ && !DMEM_RD && !DMEM_WR && !SAT_FLAG)
    else $error("pipe not empty in reset");
  a_start_fetch: assert property ($rose(RESET_N) |-> ##2
    PMEM_REQ && PMEM_ADDR == START_PC) else $error("first fetch late");
  // a decode or execute phase can only be full if the one before it was full a cycle ago
  a_phase_order: assert property (
    (PHASE_BUSY[10:5] & ~$past(PHASE_BUSY[9:4])) == '0) else $error("phase skipped");
  a_load_phases: assert property (DMEM_RD |-> PHASE_BUSY[7] ##1 PHASE_BUSY[8]
    ##1 PHASE_BUSY[9] ##1 PHASE_BUSY[10]) else $error("load phases wrong");
  a_store_phases: assert property (DMEM_WR |-> PHASE_BUSY[7] ##1 PHASE_BUSY[8])
    else $error("store phases wrong");
  a_one_mem_op: assert property (!(DMEM_RD && DMEM_WR))
    else $error("two memory ops");
  a_sat_source: assert property ($rose(SAT_FLAG) |->
    $past(PHASE_BUSY[7] || PHASE_BUSY[8])) else $error("saturation out of phase");
  a_sat_sticky: assert property (SAT_FLAG && !SAT_CLEAR |=> SAT_FLAG)
    else $error("saturation flag lost");
  a_sat_clear: assert property (SAT_CLEAR && !PHASE_BUSY[7] && !PHASE_BUSY[8]
    |=> !SAT_FLAG) else $error("clear ignored");
  a_fetch_send: assert property (PMEM_REQ |-> PHASE_BUSY[1]
    && PMEM_ADDR[4:0] == 5'h0) else $error("fetch send wrong");
  c_load: cover property (DMEM_RD);
  c_store: cover property (DMEM_WR);
  c_sat: cover property ($rose(SAT_FLAG));
endmodule : vcp_pipe_assertions
bind vcp_pipe vcp_pipe_assertions #(.START_PC(START_PC)) u_chk (.CLK(CLK),
  .RESET_N(RESET_N), .PMEM_REQ(PMEM_REQ), .PMEM_ADDR(PMEM_ADDR), .DMEM_RD(DMEM_RD),
  .DMEM_WR(DMEM_WR), .SAT_CLEAR(SAT_CLEAR), .SAT_FLAG(SAT_FLAG), .PHASE_BUSY(PHASE_BUSY));

// File: testbench/test_vcp_pipe.sv
/*
  self-checking bench for the phase sequencer.
  assumes: vcp_mem_model behind both memory ports.
*/
`timescale 1ns/1ps
module test_vcp_pipe;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic SAT_CLEAR = 1'b0;
  logic PMEM_REQ, DMEM_RD, DMEM_WR, SAT_FLAG;
  logic [31:0] PMEM_ADDR, DMEM_ADDR, DMEM_WDATA, DMEM_RDATA;
  logic [vcp_pkg::FPW-1:0] PMEM_RDATA;
  logic [vcp_pkg::NPH-1:0] PHASE_BUSY;
  int failures = 0;
  int checks_done = 0;
  always #12.5 CLK = ~CLK;
  vcp_pipe dut (.CLK(CLK), .RESET_N(RESET_N), .PMEM_REQ(PMEM_REQ), .PMEM_ADDR(PMEM_ADDR),
    .PMEM_RDATA(PMEM_RDATA), .DMEM_RD(DMEM_RD), .DMEM_WR(DMEM_WR), .DMEM_ADDR(DMEM_ADDR),
    .DMEM_WDATA(DMEM_WDATA), .DMEM_RDATA(DMEM_RDATA), .SAT_CLEAR(SAT_CLEAR),
    .SAT_FLAG(SAT_FLAG), .PHASE_BUSY(PHASE_BUSY));
  vcp_mem_model mem (.clk(CLK), .pmem_req(PMEM_REQ), .pmem_addr(PMEM_ADDR),
    .pmem_rdata(PMEM_RDATA), .dmem_rd(DMEM_RD), .dmem_wr(DMEM_WR), .dmem_addr(DMEM_ADDR),
    .dmem_wdata(DMEM_WDATA), .dmem_rdata(DMEM_RDATA));
  // one instruction, parallel bit set, unpredicated
  function automatic logic [31:0] ins(input logic [2:0] c, u, input logic [3:0] d, a, b,
                                      input logic [7:0] st);
    return {st, 5'h0, b, a, d, u, c, 1'b1};
  endfunction : ins
  // one execute packet: two lead slots, nop filler, last slot closes it
  function automatic logic [255:0] pk(input logic [31:0] i0, i1);
    return {32'h0, {5{32'h1}}, i1, i0};
  endfunction : pk
  task automatic chk(input logic [95:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  // bounded wait for the fetch of one packet address
  task automatic wait_req(input logic [31:0] a);
    int n;
    n = 0;
    while (!(PMEM_REQ === 1'b1 && PMEM_ADDR === a) && n < 300) begin
      @(negedge CLK);
      n++;
    end
    if (n == 300) begin
      failures++;
      end_sim();
    end
  endtask : wait_req
  task automatic t_reset;
    chk({PHASE_BUSY, PMEM_REQ, DMEM_RD, DMEM_WR}, '0);
    RESET_N = 1'b1;
    repeat (2) @(negedge CLK);
    for (int k = 0; k < 3; k++) begin
      chk({PMEM_REQ, PMEM_ADDR}, {1'b1, 32'(k * 32)});
      @(negedge CLK);
    end
  endtask : t_reset
  // packet 5 fetched at c0 must issue its load six cycles later
  task automatic t_loads;
    wait_req(32'ha0);
    repeat (6) @(negedge CLK);
    chk({DMEM_RD, DMEM_WR, DMEM_ADDR}, {2'b10, 32'h10});
    chk(PHASE_BUSY[6:0], 7'h7f);
    @(negedge CLK);
    chk({DMEM_RD, DMEM_ADDR}, {1'b1, 32'h14});
  endtask : t_loads
  // saturating add, multiply and stores of their results, then a false store
  task automatic t_sat_store;
    // packet 11 went out during the load checks, so sync on packet 12
    wait_req(32'h180);
    repeat (5) @(negedge CLK);
    chk(SAT_FLAG, 1'b0);
    @(negedge CLK);
    chk(SAT_FLAG, 1'b1);
    chk({DMEM_WR, DMEM_ADDR, DMEM_WDATA}, {1'b1, 32'h1c, 32'h7fffffff});
    SAT_CLEAR = 1'b1;
    @(negedge CLK);
    SAT_CLEAR = 1'b0;
    chk({DMEM_WR, DMEM_ADDR, DMEM_WDATA}, {1'b1, 32'h20, 32'hfffffc00});
    chk(SAT_FLAG, 1'b0);
    @(negedge CLK);
    chk({DMEM_WR, DMEM_RD}, 2'b00);
  endtask : t_sat_store
  // packet 16 holds two execute packets and stalls fetch; packet 20 branches
  task automatic t_branch;
    chk(PMEM_REQ, 1'b0);
    @(negedge CLK);
    chk({PMEM_REQ, PMEM_ADDR}, {1'b1, 32'h220});
    wait_req(32'h280);
    repeat (6) @(negedge CLK);
    chk({PMEM_REQ, PMEM_ADDR}, {1'b1, 32'h20});
  endtask : t_branch
  task automatic t_reset_mid;
    RESET_N = 1'b0;
    @(negedge CLK);
    chk({PHASE_BUSY, PMEM_REQ, DMEM_RD, DMEM_WR, SAT_FLAG}, '0);
  endtask : t_reset_mid
  initial begin
    for (int k = 0; k < 64; k++) begin
      mem.prog[k] = pk(32'h1, 32'h1);
    end
    mem.prog[0] = pk(ins(3'h3, 3'h0, 4'h1, 4'h0, 4'h0, 8'h0), 32'h1);
    mem.prog[5] = pk(ins(3'h3, 3'h0, 4'h2, 4'h1, 4'h0, 8'h4), 32'h1);
    mem.prog[6] = pk(ins(3'h3, 3'h0, 4'h3, 4'h1, 4'h0, 8'h4), 32'h1);
    mem.prog[7] = pk(ins(3'h3, 3'h0, 4'h6, 4'h1, 4'h0, 8'h4), 32'h1);
    mem.prog[11] = pk(ins(3'h1, 3'h0, 4'h4, 4'h2, 4'h3, 8'h0),
                      ins(3'h2, 3'h1, 4'h5, 4'h2, 4'h3, 8'h0));
    mem.prog[12] = pk(ins(3'h4, 3'h0, 4'h0, 4'h1, 4'h4, 8'h4), 32'h1);
    mem.prog[13] = pk(ins(3'h4, 3'h0, 4'h0, 4'h1, 4'h5, 8'h4), 32'h1);
    // predicated on a register that holds zero
    mem.prog[14] = pk(ins(3'h4, 3'h0, 4'h0, 4'h1, 4'h5, 8'h4) | 32'h00680000, 32'h1);
    // slot 0 closes a one-slot execute packet, the rest form a second one
    mem.prog[16] = pk(32'h0, 32'h1);
    mem.prog[20] = pk(ins(3'h5, 3'h0, 4'h0, 4'h1, 4'h0, 8'h0), 32'h1);
    mem.dm[0] = 32'h10;
    mem.dm[4] = 32'h7ffffff0;
    mem.dm[5] = 32'h20;
    mem.dm[6] = 32'h0;
    repeat (12) @(negedge CLK);
    t_reset();
    t_loads();
    t_sat_store();
    t_branch();
    t_reset_mid();
    end_sim();
  end
endmodule : test_vcp_pipe
